// File: core/dlap_pkg.sv
package dlap_pkg;
	// Serial frame: channel select on top, DAC code in the low bits
	localparam int FRAME_BITS = 16;
	localparam int CNT_W      = 4;
	localparam int CH_MSB     = 15;
	localparam int CH_LSB     = 14;
	localparam int NUM_CH     = 4;
	localparam int DATA_W     = 12;
	localparam logic [CNT_W-1:0] LAST_BIT = 4'hF;
	localparam logic [DATA_W-1:0] DAC_RESET = 12'h000;
	// Shortest strobe low time the host must give, and its cycle count
	localparam int CLK_PERIOD_NS      = 10;
	localparam int LOAD_PULSE_MIN_NS  = 20;
	localparam int LOAD_PULSE_MIN_CYC =
		(LOAD_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef logic [DATA_W-1:0] dlap_code_t;
	typedef logic [FRAME_BITS-1:0] dlap_frame_t;
endpackage

// File: core/dlap_serial_rx.sv
`timescale 1ns/1ps
module dlap_serial_rx
	import dlap_pkg::*;
(
	input  wire logic               sclk,     // Link clock
	input  wire logic               rst_n,    // Async reset
	input  wire logic               cs_n,     // Frame select, low = active
	input  wire logic               din,      // Serial data in
	output dlap_pkg::dlap_frame_t   word,     // Last complete frame
	output logic                    word_tgl, // Toggles per frame
	output logic                    dout_oe   // Pulls data-out low
);
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	dlap_frame_t      sh_r;
	dlap_frame_t      sh_nxt;
	dlap_frame_t      word_r;
	dlap_frame_t      word_nxt;
	logic             tgl_r;
	logic             tgl_nxt;
	logic             oe_r;
	logic             oe_nxt;

	assign word     = word_r;
	assign word_tgl = tgl_r;
	assign dout_oe  = oe_r;

	always_comb begin
		cnt_nxt  = (cnt_r == LAST_BIT) ? '0 : cnt_r + 1'b1;
		sh_nxt   = {sh_r[FRAME_BITS-2:0], din};
		word_nxt = word_r;
		tgl_nxt  = tgl_r;
		if (cnt_r == LAST_BIT) begin
			word_nxt = sh_nxt;
			tgl_nxt  = ~tgl_r;
		end
	end

	// The clock stops between frames, so a high select clears the count
	always_ff @(posedge sclk or negedge rst_n or posedge cs_n) begin
		if (!rst_n)
			cnt_r <= '0;
		else if (cs_n)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end

	// Word held for a full frame, so the toggle can be crossed alone
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			sh_r   <= '0;
			word_r <= '0;
			tgl_r  <= 1'b0;
		end else if (!cs_n) begin
			sh_r   <= sh_nxt;
			word_r <= word_nxt;
			tgl_r  <= tgl_nxt;
		end
	end

	always_comb begin
		oe_nxt = ~sh_r[FRAME_BITS-1];
	end

	always_ff @(negedge sclk or negedge rst_n or posedge cs_n) begin
		if (!rst_n)
			oe_r <= 1'b0;
		else if (cs_n)
			oe_r <= 1'b0;
		else
			oe_r <= oe_nxt;
	end
endmodule

// File: core/dlap_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Select low enables input; bits taken on SCLK rise, driven on fall.
// - Strobe falling edge copies every pending input register to DAC.
// - Pin-enable input gates the strobe; strobe governs loading by default.
// - Alert asserts on temperature or supply limit; polarity selectable.
module dlap_top
	import dlap_pkg::*;
(
	input  wire logic               CLK,            // System clock
	input  wire logic               RST_N,          // Async reset
	input  wire logic               CE,             // Clock enable
	input  wire logic               SCLK,           // Serial link clock
	input  wire logic               CS_N,           // Frame select
	input  wire logic               DIN,            // Serial data in
	output logic                    DOUT_O,         // Data-out level
	output logic                    DOUT_OE,        // Data-out enable
	input  wire logic               LOAD_STROBE_N,  // DAC load strobe pin
	input  wire logic               LOAD_PIN_EN,    // Strobe pin enable
	input  wire logic               SW_LOAD,        // Software load pulse
	input  wire logic               TEMP_OVER,      // Temperature over limit
	input  wire logic               VDD_OVER,       // Supply over limit
	input  wire logic               ALERT_ACT_HIGH, // Alert polarity select
	output logic                    ALERT_O,        // Alert level
	output logic                    ALERT_OE,       // Alert pull-down
	output logic [NUM_CH-1:0]       PENDING,        // New data per channel
	output dlap_pkg::dlap_code_t    DAC_A,          // DAC A code
	output dlap_pkg::dlap_code_t    DAC_B,          // DAC B code
	output dlap_pkg::dlap_code_t    DAC_C,          // DAC C code
	output dlap_pkg::dlap_code_t    DAC_D           // DAC D code
);
	dlap_frame_t         rx_word;
	logic                rx_tgl;
	logic                rx_oe;

	logic                tg_s1_r;
	logic                tg_s2_r;
	logic                tg_s3_r;
	logic                ld_s1_r;
	logic                ld_s2_r;
	logic                ld_s3_r;
	dlap_code_t          in_r    [NUM_CH];
	dlap_code_t          in_nxt  [NUM_CH];
	dlap_code_t          dac_r   [NUM_CH];
	dlap_code_t          dac_nxt [NUM_CH];
	logic [NUM_CH-1:0]   pend_r;
	logic [NUM_CH-1:0]   pend_nxt;
	logic [NUM_CH-1:0]   wr;
	logic                word_evt;
	logic                strobe_fall;
	logic                load_evt;
	logic                alert_oe_r;
	logic                alert_oe_nxt;

	dlap_serial_rx u_rx (
		.sclk     (SCLK),
		.rst_n    (RST_N),
		.cs_n     (CS_N),
		.din      (DIN),
		.word     (rx_word),
		.word_tgl (rx_tgl),
		.dout_oe  (rx_oe)
	);

	// Open drain: the module only ever pulls low
	assign DOUT_O   = 1'b0;
	assign DOUT_OE  = rx_oe;
	assign ALERT_O  = 1'b0;
	assign ALERT_OE = alert_oe_r;
	assign PENDING  = pend_r;
	assign DAC_A    = dac_r[0];
	assign DAC_B    = dac_r[1];
	assign DAC_C    = dac_r[2];
	assign DAC_D    = dac_r[3];

	// Crossing and pin synchronisers; only stage two onward is looked at
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			tg_s1_r <= 1'b0;
			tg_s2_r <= 1'b0;
			tg_s3_r <= 1'b0;
			ld_s1_r <= 1'b1;
			ld_s2_r <= 1'b1;
			ld_s3_r <= 1'b1;
		end else if (CE) begin
			tg_s1_r <= rx_tgl;
			tg_s2_r <= tg_s1_r;
			tg_s3_r <= tg_s2_r;
			ld_s1_r <= LOAD_STROBE_N;
			ld_s2_r <= ld_s1_r;
			ld_s3_r <= ld_s2_r;
		end
	end

	assign word_evt = tg_s2_r ^ tg_s3_r;

	// a 20 ns low spans at least one 10 ns sample, so no filter
	assign strobe_fall = ld_s3_r & ~ld_s2_r;

	assign load_evt = (strobe_fall & LOAD_PIN_EN) | SW_LOAD;

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			// A genvar has no bits to slice, so size it by a cast
			assign wr[g] = word_evt &&
				(rx_word[CH_MSB:CH_LSB] == (CH_MSB-CH_LSB+1)'(g));

			always_comb begin
				in_nxt[g] = wr[g] ? rx_word[DATA_W-1:0] : in_r[g];
				dac_nxt[g] = (load_evt && pend_r[g]) ? in_r[g] : dac_r[g];
				pend_nxt[g] = wr[g] | (pend_r[g] & ~load_evt);
			end

			always_ff @(posedge CLK or negedge RST_N) begin
				if (!RST_N) begin
					in_r[g]   <= DAC_RESET;
					dac_r[g]  <= DAC_RESET;
					pend_r[g] <= 1'b0;
				end else if (CE) begin
					in_r[g]   <= in_nxt[g];
					dac_r[g]  <= dac_nxt[g];
					pend_r[g] <= pend_nxt[g];
				end
			end
		end
	endgenerate

	always_comb begin
		// Active high on an open-drain pin means release while asserted
		alert_oe_nxt = (TEMP_OVER | VDD_OVER) ^ ALERT_ACT_HIGH;
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			alert_oe_r <= 1'b0;
		else if (CE)
			alert_oe_r <= alert_oe_nxt;
	end
endmodule

// File: dv/dlap_top_properties.sv
`timescale 1ns/1ps
module dlap_top_properties
	import dlap_pkg::*;
(
	input wire logic              CLK,            // clk
	input wire logic              RST_N,          // reset
	input wire logic              CE,             // enable
	input wire logic              CS_N,           // select
	input wire logic              DOUT_OE,        // out
	input wire logic              LOAD_STROBE_N,  // strobe
	input wire logic              LOAD_PIN_EN,    // pin en
	input wire logic              SW_LOAD,        // sw load
	input wire logic              TEMP_OVER,      // temp
	input wire logic              VDD_OVER,       // supply
	input wire logic              ALERT_ACT_HIGH, // polarity
	input wire logic              ALERT_OE,       // alert
	input wire logic [NUM_CH-1:0] PENDING         // pending
);
	wire alert_want = (TEMP_OVER | VDD_OVER) ^ ALERT_ACT_HIGH;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	AST_ALERT: assert property (
		$past(RST_N) && $past(CE) |-> ALERT_OE == $past(alert_want))
		else $error("alert level wrong");
	AST_HOLD: assert property (
		!SW_LOAD && !LOAD_PIN_EN |=> (PENDING | ~$past(PENDING)) == '1)
		else $error("pending lost without load");
	AST_SW: assert property (SW_LOAD && CE |=> PENDING == '0)
		else $error("sw load left pending");
	AST_PIN: assert property (
		$fell(LOAD_STROBE_N) && LOAD_PIN_EN |-> ##[2:5] PENDING == '0)
		else $error("strobe load late");
	AST_IDLE: assert property ($past(CS_N) && CS_N |-> !DOUT_OE)
		else $error("data out driven idle");
	cover property (SW_LOAD && PENDING != '0);
	cover property ($rose(ALERT_OE));
	cover property ($fell(LOAD_STROBE_N) && LOAD_PIN_EN);
endmodule
bind dlap_top dlap_top_properties u_prop (.CLK(CLK), .RST_N(RST_N),
	.CE(CE), .CS_N(CS_N), .DOUT_OE(DOUT_OE), .LOAD_STROBE_N(LOAD_STROBE_N),
	.LOAD_PIN_EN(LOAD_PIN_EN), .SW_LOAD(SW_LOAD), .TEMP_OVER(TEMP_OVER),
	.VDD_OVER(VDD_OVER), .ALERT_ACT_HIGH(ALERT_ACT_HIGH),
	.ALERT_OE(ALERT_OE), .PENDING(PENDING));

// File: dv/dlap_host_model.sv
`timescale 1ns/1ps
module dlap_host_model (
	output logic sclk,              // Link clock
	output logic cs_n,              // Frame select
	output logic din,               // Data
	output logic dac_load_strobe_n  // Load strobe
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
		dac_load_strobe_n = 1'b1;
	end
	task automatic send(input logic [15:0] f, input int n);
		cs_n = 1'b0;
		for (int i = 15; i > 15 - n; i--) begin
			din = f[i];
			#62.5 sclk = 1'b1;
			#62.5 sclk = 1'b0;
		end
		#62.5 cs_n = 1'b1;
		din = ~din;
	endtask
	task automatic strobe();
		dac_load_strobe_n = 1'b0;
		#30 dac_load_strobe_n = 1'b1;
		#30;
	endtask
endmodule

// File: dv/dlap_top_tb_top.sv
`timescale 1ns/1ps
module dlap_top_tb_top;
	import dlap_pkg::*;
	logic clk = 0, rst_n = 0, sw = 0, pen = 1, tov = 0, vov = 0, hi = 0;
	logic ce = 1;
	logic sclk, cs_n, din, ld_n, doe, aoe;
	logic [3:0] pend;
	dlap_code_t dac [4];
	dlap_code_t exp [4] = '{default: 12'h000};
	int error_cnt = 0, samples_checked = 0, cyc = 0;
	localparam logic [15:0] ROWS [4] = '{16'h3123, 16'h7ABC, 16'hBFFF, 16'hC800};
	always #5 clk = ~clk;
	dlap_top DUT (.CLK(clk), .RST_N(rst_n), .CE(ce), .SCLK(sclk),
		.CS_N(cs_n), .DIN(din), .DOUT_O(), .DOUT_OE(doe),
		.LOAD_STROBE_N(ld_n), .LOAD_PIN_EN(pen), .SW_LOAD(sw),
		.TEMP_OVER(tov), .VDD_OVER(vov), .ALERT_ACT_HIGH(hi), .ALERT_O(),
		.ALERT_OE(aoe), .PENDING(pend), .DAC_A(dac[0]), .DAC_B(dac[1]),
		.DAC_C(dac[2]), .DAC_D(dac[3]));
	dlap_host_model u_host (.sclk(sclk), .cs_n(cs_n), .din(din),
		.dac_load_strobe_n(ld_n));
	task automatic chk(input string nm, input logic [15:0] e, g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic dacs();
		for (int i = 0; i < 4; i++)
			chk("dac", {4'h0, exp[i]}, {4'h0, dac[i]});
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic end_of_test();
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			end_of_test();
		end
	end
	initial begin
		wt(3);
		rst_n = 1;
		dacs();
		u_host.send(16'h4555, 8);
		wt(10);
		chk("pend", 0, {12'h0, pend});
		foreach (ROWS[r]) begin
			u_host.send(ROWS[r], 16);
			wt(10);
			chk("pend", {12'h0, 4'h1 << ROWS[r][15:14]}, {12'h0, pend});
			chk("doe", 16'h0, {15'h0, doe});
			u_host.strobe();
			wt(6);
			exp[ROWS[r][15:14]] = ROWS[r][11:0];
			dacs();
			chk("pend", 0, {12'h0, pend});
		end
		pen = 0;
		u_host.send(16'h0456, 16);
		u_host.strobe();
		wt(10);
		dacs();
		ce = 0;
		sw = 1;
		wt(2);
		sw = 0;
		chk("pend", 16'h1, {12'h0, pend});
		ce = 1;
		wt(1);
		sw = 1;
		wt(1);
		sw = 0;
		wt(2);
		exp[0] = 12'h456;
		dacs();
		for (int k = 0; k < 8; k++) begin
			{tov, vov, hi} = k[2:0];
			wt(2);
			chk("alert", {15'h0, (k[2] | k[1]) ^ k[0]}, {15'h0, aoe});
		end
		rst_n = 0;
		wt(1);
		exp = '{default: 12'h000};
		dacs();
		rst_n = 1;
		wt(2);
		chk("pend", 16'h0, {12'h0, pend});
		chk("alert", 16'h0, {15'h0, aoe});
		end_of_test();
	end
endmodule
